// ===== vref_pkg.sv
/*
  Package for the fixed voltage reference control block: register map, field
  positions, reset values, settling count and state encodings.
  Assumes a single 250 MHz clock domain with synchronous active-high reset.
*/
package vref_pkg;
  localparam logic [11:0] ADDR_CONTROL = 12'h000;
  localparam logic [11:0] ADDR_IRQ_STATUS = 12'h004;
  localparam logic [11:0] ADDR_IRQ_MASK = 12'h008;
  localparam logic [11:0] ADDR_SETTLE_COUNT = 12'h00c;

  localparam int BIT_ENABLE = 7;
  localparam int BIT_READY = 6;
  localparam int BIT_GAIN_HI = 5;
  localparam int BIT_GAIN_LO = 4;
  localparam logic [7:0] CONTROL_WRITE_MASK = 8'hb0;
  localparam logic [7:0] CONTROL_RESET = 8'h10;

  localparam int IRQ_READY_RISE = 0;
  localparam int IRQ_READY_FALL = 1;
  localparam logic [1:0] IRQ_RESET = 2'h0;

  localparam int SETTLE_TIME_NS = 25000;
  localparam int CLK_PERIOD_NS = 4;
  localparam int SETTLE_CYCLES = (SETTLE_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int SETTLE_WIDTH = 16;

  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  typedef enum logic [1:0] {
    GAIN_OFF = 2'b00,
    GAIN_1X = 2'b01,
    GAIN_2X = 2'b10,
    GAIN_4X = 2'b11
  } gain_t;

  typedef enum logic [1:0] {
    REF_OFF = 2'b00,
    REF_SETTLING = 2'b01,
    REF_READY = 2'b10
  } ref_state_t;
endpackage

// ===== vref_settle.sv
/*
  Settling timer: counts cycles after enable and reports when the reference
  and its amplifiers may be used.
  Assumes enable comes from logic on the same clock.
*/
`timescale 1ns/1ns
`default_nettype none
module vref_settle import vref_pkg::*; #(
  parameter int SETTLE_CYCLES_P = SETTLE_CYCLES
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic enable,
  output var logic ready,
  output var logic [1:0] state_out
);
  typedef struct packed {
    ref_state_t state;
    logic [SETTLE_WIDTH-1:0] count;
  } settle_t;

  localparam logic [SETTLE_WIDTH-1:0] LAST = SETTLE_WIDTH'(SETTLE_CYCLES_P - 1);

  settle_t cur;
  settle_t next_cur;

  always_comb begin
    next_cur = cur;
    case (cur.state)
      REF_OFF: begin
        next_cur.count = '0;
        if (enable) begin
          next_cur.state = REF_SETTLING;
        end
      end
      REF_SETTLING: begin
        if (!enable) begin
          next_cur.state = REF_OFF;
        end else if (cur.count == LAST) begin
          next_cur.state = REF_READY;
        end else begin
          next_cur.count = cur.count + 1'b1;
        end
      end
      REF_READY: begin
        if (!enable) begin
          next_cur.state = REF_OFF;
        end
      end
      default: next_cur.state = REF_OFF;
    endcase
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      cur <= '{state: REF_OFF, count: '0};
    end else begin
      cur <= next_cur;
    end
  end

  assign ready = (cur.state == REF_READY);
  assign state_out = cur.state;
endmodule
`default_nettype wire

// ===== vref_gain_decode.sv
/*
  Gain decoder: turns the two-bit gain field into one-hot amplifier selects.
  Assumes the select is only honoured while the reference is settled.
*/
`timescale 1ns/1ns
`default_nettype none
module vref_gain_decode import vref_pkg::*; (
  input wire logic [1:0] gain_select,
  input wire logic usable,
  output var logic [2:0] gain_onehot
);
  always_comb begin
    gain_onehot = 3'h0;
    if (usable) begin
      case (gain_t'(gain_select))
        GAIN_1X: gain_onehot = 3'h1;
        GAIN_2X: gain_onehot = 3'h2;
        GAIN_4X: gain_onehot = 3'h4;
        default: gain_onehot = 3'h0;
      endcase
    end
  end
endmodule
`default_nettype wire

// ===== vref_control.sv
/*
  Fixed voltage reference control: AXI4-Lite register slave, enable/gain
  control, settling tracking, ready flag and interrupt on ready changes.
  Assumes a single clock, synchronous reset and a well-behaved AXI4-Lite master
  with at most one write and one read outstanding.
*/
`timescale 1ns/1ns
`default_nettype none
module vref_control import vref_pkg::*; #(
  parameter int SETTLE_CYCLES_P = SETTLE_CYCLES
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic [11:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [11:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  output logic reference_enable,
  output logic reference_ready,
  output logic [2:0] gain_onehot,
  output logic irq
);
  typedef struct packed {
    logic aw_held;
    logic [11:0] aw_addr;
    logic w_held;
    logic [31:0] w_data;
    logic [3:0] w_strb;
    logic bvalid;
    logic [1:0] bresp;
    logic rvalid;
    logic [31:0] rdata;
    logic [1:0] rresp;
    logic enable;
    logic [1:0] gain;
    logic ready;
    logic [1:0] irq_status;
    logic [1:0] irq_mask;
    logic [2:0] onehot;
    logic irq;
    logic awready;
    logic wready;
    logic arready;
  } regs_t;

  regs_t r;
  regs_t next_r;
  logic settled;
  logic [2:0] decoded;

  // Ready is visible in the register only while the block is still enabled
  function automatic logic [7:0] control_image(logic en, logic rdy, logic [1:0] g);
    logic [7:0] v;
    v = 8'h00;
    v[BIT_ENABLE] = en;
    v[BIT_READY] = rdy;
    v[BIT_GAIN_HI:BIT_GAIN_LO] = g;
    return v;
  endfunction

  vref_settle #(.SETTLE_CYCLES_P(SETTLE_CYCLES_P)) u_settle (
    .clk(clk),
    .rst(rst),
    .enable(r.enable),
    .ready(settled),
    .state_out()
  );

  vref_gain_decode u_gain (
    .gain_select(r.gain),
    .usable(settled & r.enable),
    .gain_onehot(decoded)
  );

  always_comb begin
    logic do_write;
    logic [1:0] events;
    logic [1:0] w1c;
    do_write = 1'b0;
    events = 2'h0;
    w1c = 2'h0;
    next_r = r;

    if (s_axi_awvalid && !r.aw_held) begin
      next_r.aw_held = 1'b1;
      next_r.aw_addr = s_axi_awaddr;
    end
    if (s_axi_wvalid && !r.w_held) begin
      next_r.w_held = 1'b1;
      next_r.w_data = s_axi_wdata;
      next_r.w_strb = s_axi_wstrb;
    end
    if (s_axi_bvalid && s_axi_bready) begin
      next_r.bvalid = 1'b0;
    end

    // Both halves held and no response pending: perform the write
    if (r.aw_held && r.w_held && !r.bvalid) begin
      do_write = 1'b1;
      next_r.aw_held = 1'b0;
      next_r.w_held = 1'b0;
      next_r.bvalid = 1'b1;
      next_r.bresp = RESP_OKAY;
      if (r.aw_addr == ADDR_CONTROL) begin
        if (r.w_strb[0]) begin
          next_r.enable = r.w_data[BIT_ENABLE];
          next_r.gain = r.w_data[BIT_GAIN_HI:BIT_GAIN_LO];
        end
      end else if (r.aw_addr == ADDR_IRQ_STATUS) begin
        if (r.w_strb[0]) begin
          w1c = r.w_data[1:0];
        end
      end else if (r.aw_addr == ADDR_IRQ_MASK) begin
        if (r.w_strb[0]) begin
          next_r.irq_mask = r.w_data[1:0];
        end
      end else if (r.aw_addr == ADDR_SETTLE_COUNT) begin
        next_r.bresp = RESP_OKAY;
      end else begin
        next_r.bresp = RESP_SLVERR;
      end
    end

    // Ready drops the same cycle the enable is written low
    next_r.ready = settled && next_r.enable && !(do_write && !next_r.enable);
    events[IRQ_READY_RISE] = next_r.ready && !r.ready;
    events[IRQ_READY_FALL] = !next_r.ready && r.ready;
    // A new event wins over a simultaneous clear
    next_r.irq_status = (r.irq_status & ~w1c) | events;
    next_r.irq = |(next_r.irq_status & r.irq_mask);
    next_r.onehot = next_r.ready ? decoded : 3'h0;

    if (s_axi_rvalid && s_axi_rready) begin
      next_r.rvalid = 1'b0;
    end
    if (s_axi_arvalid && !r.rvalid) begin
      next_r.rvalid = 1'b1;
      next_r.rresp = RESP_OKAY;
      next_r.rdata = 32'h0;
      if (s_axi_araddr == ADDR_CONTROL) begin
        next_r.rdata = {24'h0, control_image(r.enable, r.ready, r.gain)};
      end else if (s_axi_araddr == ADDR_IRQ_STATUS) begin
        next_r.rdata = {30'h0, r.irq_status};
      end else if (s_axi_araddr == ADDR_IRQ_MASK) begin
        next_r.rdata = {30'h0, r.irq_mask};
      end else if (s_axi_araddr == ADDR_SETTLE_COUNT) begin
        next_r.rdata = 32'(SETTLE_CYCLES_P);
      end else begin
        next_r.rresp = RESP_SLVERR;
      end
    end
    // Ready lines kept in flops so no bus output goes through logic
    next_r.awready = !next_r.aw_held;
    next_r.wready = !next_r.w_held;
    next_r.arready = !next_r.rvalid;
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      r <= '0;
      r.gain <= CONTROL_RESET[BIT_GAIN_HI:BIT_GAIN_LO];
      r.irq_status <= IRQ_RESET;
      r.irq_mask <= IRQ_RESET;
      r.awready <= 1'b1;
      r.wready <= 1'b1;
      r.arready <= 1'b1;
    end else begin
      r <= next_r;
    end
  end

  assign s_axi_awready = r.awready;
  assign s_axi_wready = r.wready;
  assign s_axi_bvalid = r.bvalid;
  assign s_axi_bresp = r.bresp;
  assign s_axi_arready = r.arready;
  assign s_axi_rvalid = r.rvalid;
  assign s_axi_rdata = r.rdata;
  assign s_axi_rresp = r.rresp;
  assign reference_enable = r.enable;
  assign reference_ready = r.ready;
  assign gain_onehot = r.onehot;
  assign irq = r.irq;
endmodule
`default_nettype wire

// ===== vref_control_monitor.sv
/* Checker on the ports of the reference control block.
   Assumes the bench runs the settling count at 8 cycles. */
`timescale 1ns/1ns
`default_nettype none
module vref_control_monitor (
  input wire logic clk,
  input wire logic rst,
  input wire logic [11:0] s_axi_araddr,
  input wire logic [31:0] s_axi_rdata,
  input wire logic s_axi_rvalid,
  input wire logic s_axi_bvalid,
  input wire logic reference_enable,
  input wire logic reference_ready,
  input wire logic [2:0] gain_onehot,
  input wire logic irq
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);
  // Cycles the enable has stood high without a break, saturating
  logic [4:0] on_cycles;
  always_ff @(posedge clk) begin
    if (rst || !reference_enable) begin
      on_cycles <= 5'h00;
    end else if (on_cycles != 5'h1f) begin
      on_cycles <= on_cycles + 5'h01;
    end
  end
  AST_READY_NEEDS_EN: assert property (reference_ready |-> reference_enable)
    else $error("ready seen while disabled");
  AST_SETTLE_MIN: assert property ($rose(reference_ready) |-> on_cycles >= 5'h08)
    else $error("ready rose too early");
  AST_READY_SOON: assert property ($rose(reference_enable) |->
    ##[1:20] (reference_ready || !reference_enable))
    else $error("ready never rose");
  AST_GAIN_IDLE: assert property (!reference_ready |-> gain_onehot == 3'h0)
    else $error("gain select live before settled");
  AST_GAIN_ONE: assert property (reference_ready |-> $onehot0(gain_onehot))
    else $error("several gains at once");
  AST_LOW_ZERO: assert property ($rose(s_axi_rvalid) && $past(s_axi_araddr) == 12'h000
    |-> s_axi_rdata[3:0] == 4'h0)
    else $error("low control bits not zero");
  AST_EN_BY_WRITE: assert property ($changed(reference_enable) |-> $rose(s_axi_bvalid))
    else $error("enable moved without a write");
  AST_DROP_NOW: assert property ($fell(reference_enable) |-> !reference_ready)
    else $error("ready outlived enable");
  cover property ($rose(reference_ready));
  cover property ($fell(reference_enable));
  cover property ($rose(irq));
endmodule
bind vref_control vref_control_monitor i_vref_control_monitor (.clk, .rst, .s_axi_araddr,
  .s_axi_rdata, .s_axi_rvalid, .s_axi_bvalid, .reference_enable, .reference_ready,
  .gain_onehot, .irq);
`default_nettype wire

// ===== tb.sv
/* Self-checking bench for the reference control block over AXI4-Lite.
   Assumes the block answers by its own handshakes; settling count set to 8. */
`timescale 1ns/1ns
`default_nettype none
module tb import vref_pkg::*;;
  localparam int SETTLE_SIM = 8;
  logic clk = 0, rst = 1;
  logic [3:0] wstrb = 4'h1;
  logic [11:0] awaddr = 0, araddr = 0;
  logic [31:0] wdata = 0, rdata;
  logic awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0;
  logic awready, wready, bvalid, arready, rvalid, en, rdy, irq;
  logic [1:0] bresp, rresp, resp;
  logic [2:0] onehot;
  logic [31:0] d;
  int n_errors = 0, tests_run = 0, cyc = 0;
  vref_control #(.SETTLE_CYCLES_P(SETTLE_SIM)) i_vref_control (.clk(clk), .rst(rst),
    .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
    .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
    .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
    .reference_enable(en), .reference_ready(rdy), .gain_onehot(onehot), .irq(irq));
  initial forever #2 clk = ~clk;
  task automatic complete_run;
    if (n_errors == 0 && tests_run > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask
  always @(posedge clk) begin
    cyc++;
    if (cyc == 5000) begin
      n_errors++;
      complete_run();
    end
  end
  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] s);
    tests_run++;
    if (s !== e) begin
      $display("[ERR] %s expected %h seen %h", n, e, s);
      n_errors++;
    end
  endtask
  // Ready levels are read just after an edge, before that edge's updates land
  // One idle edge first, so a ready lowered by the previous call is not raised in the same step
  task automatic wr(input logic [11:0] a, input logic [31:0] v);
    @(posedge clk);
    awaddr <= a; wdata <= v; awvalid <= 1; wvalid <= 1; bready <= 1;
    do begin
      @(posedge clk);
      if (awready) awvalid <= 0;
      if (wready) wvalid <= 0;
    end while (bvalid !== 1'b1);
    resp = bresp;
    bready <= 0;
  endtask
  task automatic rd(input logic [11:0] a);
    @(posedge clk);
    araddr <= a; arvalid <= 1; rready <= 1;
    do begin
      @(posedge clk);
      if (arready) arvalid <= 0;
    end while (rvalid !== 1'b1);
    d = rdata; resp = rresp;
    rready <= 0;
  endtask
  task automatic t_reset;
    rd(ADDR_CONTROL);
    chk("control reset", {24'h0, CONTROL_RESET}, d);
    chk("ready reset", 0, rdy);
    rd(ADDR_SETTLE_COUNT);
    chk("settle count", SETTLE_SIM, d);
  endtask
  task automatic t_gain(input logic [1:0] g);
    int n;
    wr(ADDR_CONTROL, {24'h0, 2'b10, g, 4'hf});
    chk("bresp", RESP_OKAY, resp);
    chk("enable", 1, en);
    for (n = 0; n < 40 && rdy !== 1'b1; n++) @(posedge clk);
    chk("settled late", 1, rdy);
    chk("settled early", 1, n >= SETTLE_SIM);
    chk("onehot", g == 0 ? 3'h0 : 3'h1 << (g - 1), onehot);
    rd(ADDR_CONTROL);
    chk("control", {24'h0, 2'b11, g, 4'h0}, d);
    wr(ADDR_CONTROL, {24'h0, 2'b00, g, 4'h0});
    chk("ready drop", 0, rdy);
    chk("disable", 0, en);
  endtask
  task automatic t_irq;
    wr(ADDR_IRQ_MASK, 1);
    repeat (2) @(posedge clk);
    chk("irq on", 1, irq);
    rd(ADDR_IRQ_STATUS);
    chk("status", 3, d);
    wr(ADDR_IRQ_STATUS, 1);
    repeat (2) @(posedge clk);
    chk("irq off", 0, irq);
    rd(ADDR_IRQ_STATUS);
    chk("status w1c", 2, d);
    rd(12'h010);
    chk("unmapped", RESP_SLVERR, resp);
    wstrb <= 4'h0;
    wr(ADDR_IRQ_MASK, 3);
    wstrb <= 4'h1;
    rd(ADDR_IRQ_MASK);
    chk("strobe off", 1, d);
    wr(12'h010, 0);
    chk("unmapped write", RESP_SLVERR, resp);
  endtask
  initial begin
    repeat (20) @(posedge clk);
    rst <= 0;
    repeat (2) @(posedge clk);
    t_reset();
    for (int g = 0; g < 4; g++) t_gain(g[1:0]);
    t_irq();
    complete_run();
  end
endmodule
`default_nettype wire
